// [rtl/ssv_pkg.sv]
// Package for the low- and high-side supply supervisors and low-power control block
package ssv_pkg;
   // Clock and timing
   localparam int CLK_MHZ = 25;
   localparam int FP_SETTLE_NS = 2000;
   localparam int NORM_SETTLE_US = 150;
   localparam int WAKE_SLOW_US = 150;
   localparam int HANG_WIN_NS = 1000;
   localparam int FP_SETTLE_CYC = (FP_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int NORM_SETTLE_CYC = NORM_SETTLE_US * CLK_MHZ;
   localparam int WAKE_SLOW_CYC = WAKE_SLOW_US * CLK_MHZ;
   localparam int WAKE_FAST_CYC = FP_SETTLE_CYC;
   localparam int HANG_WIN_CYC = HANG_WIN_NS * CLK_MHZ / 1000;
   localparam int CNT_W = 16;
   // Register word addresses (byte address / 4)
   localparam logic [3:0] ADDR_LOW_CTL = 4'h0;
   localparam logic [3:0] ADDR_HIGH_CTL = 4'h1;
   localparam logic [3:0] ADDR_FLAGS = 4'h2;
   localparam logic [3:0] ADDR_MODE = 4'h3;
   localparam logic [3:0] ADDR_STATE = 4'h4;
   localparam logic [3:0] ADDR_OPT = 4'h5;
   // Supervisor control field positions (low and high share layout)
   localparam int SUP_EN_BIT = 0;
   localparam int SUP_MD_BIT = 1;
   localparam int SUP_FP_BIT = 2;
   localparam int MON_EN_BIT = 3;
   localparam int MON_FP_BIT = 4;
   localparam int AUTO_BIT = 5;
   localparam int CTL_W = 6;
   localparam logic [CTL_W-1:0] LOW_CTL_RST = 6'h05;
   localparam logic [CTL_W-1:0] HIGH_CTL_RST = 6'h05;
   // Flags register bit positions
   localparam int FLG_LOW_DLY_BIT = 0;
   localparam int FLG_HIGH_DLY_BIT = 1;
   localparam int FLG_CORE_RST_BIT = 2;
   localparam int FLG_HUNG_BIT = 3;
   // Option register bit positions
   localparam int OPT_DEFECT_BIT = 0;
   localparam int OPT_CLKREQ_BIT = 1;
   localparam logic [1:0] OPT_RST = 2'h3;
   // Power modes
   typedef enum logic [2:0] {
      PM_ACTIVE, PM_LP0, PM_LP1, PM_LP2, PM_LP3, PM_LP4
   } ssv_pmode_e;
   // Supervisor or monitor operating state
   typedef enum logic [1:0] {SS_OFF, SS_NORMAL, SS_FULLPERF} ssv_sstate_e;
   // Sequencer states
   typedef enum logic [1:0] {SQ_RUN, SQ_SLEEP, SQ_WAKE, SQ_HUNG} ssv_seq_e;
   // Supervisor control word
   typedef struct packed {
      logic autoCtl;
      logic monFullPerf;
      logic monEnable;
      logic supFullPerf;
      logic supModeSel;
      logic supEnable;
   } ssv_ctl_s;
   // Supervisor and monitor state pair
   typedef struct packed {
      ssv_sstate_e sup;
      ssv_sstate_e mon;
   } ssv_pair_s;

   function automatic logic isDeep(input ssv_pmode_e m);
      return (m == PM_LP2) || (m == PM_LP3) || (m == PM_LP4);
   endfunction : isDeep

   // Supervisor and monitor states for a control word in a power mode
   function automatic ssv_pair_s pairState(input ssv_ctl_s c, input logic deep);
      ssv_pair_s p;
      p.sup = SS_OFF;
      p.mon = SS_OFF;
      if (c.supEnable) begin
         if (!deep) begin
            p.sup = c.supFullPerf ? SS_FULLPERF : SS_NORMAL;
         end else if (c.supModeSel) begin
            if (!c.autoCtl) begin
               p.sup = c.supFullPerf ? SS_FULLPERF : SS_NORMAL;
            end else begin
               p.sup = c.supFullPerf ? SS_NORMAL : SS_OFF;
            end
         end
      end
      if (c.monEnable) begin
         if (!deep || !c.autoCtl) begin
            p.mon = c.monFullPerf ? SS_FULLPERF : SS_NORMAL;
         end else begin
            p.mon = c.monFullPerf ? SS_NORMAL : SS_OFF;
         end
      end
      return p;
   endfunction : pairState
endpackage : ssv_pkg

// [rtl/ssv_settle_timer.sv]
// Settling-delay timer: flag set on start, cleared when the delay elapses
`timescale 1ns/10ps
module ssv_settle_timer
   import ssv_pkg::*;
#(
   parameter int CW = CNT_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clkEn,
   // Control
   input wire logic start,
   input wire logic [CW-1:0] length,
   // Status
   output logic busy,
   output logic expired
);
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic busy_r;
   logic busy_nxt;
   logic expired_nxt;
   logic expired_r;

   always_comb begin
      count_nxt = count_r;
      busy_nxt = busy_r;
      expired_nxt = 1'b0;
      if (start) begin
         count_nxt = length;
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         if (count_r <= CW'(1)) begin
            busy_nxt = 1'b0;
            expired_nxt = 1'b1;
         end else begin
            count_nxt = count_r - CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_r <= '0;
         busy_r <= 1'b0;
         expired_r <= 1'b0;
      end else if (clkEn) begin
         count_r <= count_nxt;
         busy_r <= busy_nxt;
         expired_r <= expired_nxt;
      end
   end

   assign busy = busy_r;
   assign expired = expired_r;
endmodule : ssv_settle_timer

// [rtl/ssv_supervisor_ctl.sv]
// Low- and high-side supply supervisors, settling delays and low-power wake control
`timescale 1ns/10ps
module ssv_supervisor_ctl
   import ssv_pkg::*;
#(
   parameter int NORM_CYC = NORM_SETTLE_CYC,
   parameter int SLOW_CYC = WAKE_SLOW_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clkEn,
   // Avalon-MM slave
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   // Power-mode request from the core, and wake interrupt pin
   input wire logic [2:0] sleepModeReq,
   input wire logic sleepEnter,
   input wire logic wakeIrqPin,
   input wire logic powerUpClear,
   // Core voltage level request
   input wire logic [1:0] coreLevelReq,
   // Status outputs
   output logic cpuMask,
   output logic coreResetReq,
   output logic wakeHung,
   output logic [1:0] coreLevel,
   output ssv_pair_s lowState,
   output ssv_pair_s highState
);
   localparam logic [CNT_W-1:0] FP_LEN = CNT_W'(FP_SETTLE_CYC);
   localparam logic [CNT_W-1:0] NORM_LEN = CNT_W'(NORM_CYC);
   localparam logic [CNT_W-1:0] SLOW_LEN = CNT_W'(SLOW_CYC);
   localparam logic [CNT_W-1:0] FAST_LEN = CNT_W'(WAKE_FAST_CYC);
   localparam logic [CNT_W-1:0] WIN_LEN = CNT_W'(HANG_WIN_CYC);

   // Register hit: every writable field sits in lane 0, so that lane must be enabled
   function automatic logic regHit(input logic [3:0] a, input logic [3:0] be,
         input logic [3:0] target);
      return (a == target) && be[0];
   endfunction : regHit

   // Settling length: short with full performance, long in normal mode
   function automatic logic [CNT_W-1:0] settleLen(input logic fullPerf);
      return fullPerf ? FP_LEN : NORM_LEN;
   endfunction : settleLen

   // Register state
   ssv_ctl_s lowCtl_r, lowCtl_nxt;
   ssv_ctl_s highCtl_r, highCtl_nxt;
   logic [1:0] opt_r, opt_nxt;
   logic coreRst_r, coreRst_nxt;
   logic [1:0] level_r, level_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // Sequencer state
   ssv_seq_e seq_r, seq_nxt;
   ssv_pmode_e mode_r, mode_nxt;
   logic [CNT_W-1:0] wakeCnt_r, wakeCnt_nxt;
   logic [CNT_W-1:0] winCnt_r, winCnt_nxt;
   logic riskEntry_r, riskEntry_nxt;

   // Pin synchronisers
   logic irqMeta_r, irqSync_r, pucMeta_r, pucSync_r;

   logic wrLow, wrHigh, lowBusy, highBusy, lowDone, levelUp;
   logic deep, fastWake, highDropsOff, dirtyEntry, lowFastCfg;
   logic wr, rd;
   logic wrMode, wrOpt, wrFlags;
   ssv_pair_s lowDeep, highAct, highDeepS;

   // Input pins cross into the clock domain through two stages
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         irqMeta_r <= 1'b0;
         irqSync_r <= 1'b0;
         pucMeta_r <= 1'b0;
         pucSync_r <= 1'b0;
      end else if (clkEn) begin
         irqMeta_r <= wakeIrqPin;
         irqSync_r <= irqMeta_r;
         pucMeta_r <= powerUpClear;
         pucSync_r <= pucMeta_r;
      end
   end

   // Two-edge access: the first edge sees the request with ack low and registers
   // read data; writes land on the second edge, where waitrequest is low, so no
   // state changes before the master knows its request was taken.
   assign wr = avsWrite && ack_r;
   assign rd = avsRead && !ack_r;
   assign avsWaitRequest = (avsRead || avsWrite) && !ack_r;
   assign avsReadData = rdata_r;

   assign wrLow = wr && regHit(avsAddress, avsByteEnable, ADDR_LOW_CTL);
   assign wrHigh = wr && regHit(avsAddress, avsByteEnable, ADDR_HIGH_CTL);
   assign wrMode = wr && regHit(avsAddress, avsByteEnable, ADDR_MODE);
   assign wrOpt = wr && regHit(avsAddress, avsByteEnable, ADDR_OPT);
   assign wrFlags = wr && regHit(avsAddress, avsByteEnable, ADDR_FLAGS);
   assign levelUp = wrMode && 2'(avsWriteData[1:0]) > level_r;

   ssv_settle_timer u_low_timer (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(clkEn),
      .start(wrLow || levelUp),
      .length(settleLen(lowCtl_nxt.supFullPerf)),
      .busy(lowBusy),
      .expired(lowDone)
   );

   // High side feeds its flag and the dirty-entry check; its expiry pulse is not needed here
   ssv_settle_timer u_high_timer (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(clkEn),
      .start(wrHigh),
      .length(settleLen(highCtl_nxt.supFullPerf)),
      .busy(highBusy),
      .expired()
   );

   assign deep = isDeep(mode_r);
   assign lowState = pairState(lowCtl_r, deep);
   assign highState = pairState(highCtl_r, deep);
   assign lowDeep = pairState(lowCtl_r, 1'b1);
   assign highAct = pairState(highCtl_r, 1'b0);
   assign highDeepS = pairState(highCtl_r, 1'b1);

   assign lowFastCfg = !lowCtl_r.supEnable || lowCtl_r.supFullPerf
      || !lowCtl_r.monEnable || lowCtl_r.monFullPerf;
   assign fastWake = lowFastCfg;
   assign highDropsOff = (highAct.sup == SS_NORMAL && highDeepS.sup == SS_OFF)
      || (highAct.mon == SS_NORMAL && highDeepS.mon == SS_OFF);
   assign dirtyEntry = lowBusy || highBusy;

   always_comb begin
      lowCtl_nxt = lowCtl_r;
      highCtl_nxt = highCtl_r;
      opt_nxt = opt_r;
      level_nxt = level_r;
      coreRst_nxt = coreRst_r;
      ack_nxt = 1'b0;
      rdata_nxt = rdata_r;
      if ((avsRead || avsWrite) && !ack_r) begin
         ack_nxt = 1'b1;
      end
      if (wrLow) begin
         lowCtl_nxt = ssv_ctl_s'(avsWriteData[CTL_W-1:0]);
      end
      if (wrHigh) begin
         highCtl_nxt = ssv_ctl_s'(avsWriteData[CTL_W-1:0]);
      end
      if (wrMode) begin
         level_nxt = avsWriteData[1:0];
      end
      if (wrOpt) begin
         opt_nxt = avsWriteData[1:0];
      end
      // Core-level reset flag clears on write of one; a new event wins
      if (wrFlags && avsWriteData[FLG_CORE_RST_BIT]) begin
         coreRst_nxt = 1'b0;
      end
      if (levelUp && lowCtl_r.supFullPerf && opt_r[OPT_DEFECT_BIT]) begin
         coreRst_nxt = 1'b1;
      end
      // Flags read live timer state; bit 2 is the only writable one
      if (rd) begin
         unique case (avsAddress)
            ADDR_LOW_CTL: rdata_nxt = 32'(lowCtl_r);
            ADDR_HIGH_CTL: rdata_nxt = 32'(highCtl_r);
            ADDR_FLAGS: rdata_nxt = 32'({seq_r == SQ_HUNG, coreRst_r, highBusy, lowBusy});
            ADDR_MODE: rdata_nxt = 32'(level_r);
            ADDR_STATE: rdata_nxt = 32'({fastWake, highState, lowState});
            ADDR_OPT: rdata_nxt = 32'(opt_r);
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_comb begin
      seq_nxt = seq_r;
      mode_nxt = mode_r;
      wakeCnt_nxt = wakeCnt_r;
      winCnt_nxt = winCnt_r;
      riskEntry_nxt = riskEntry_r;
      unique case (seq_r)
         SQ_RUN: begin
            if (sleepEnter && sleepModeReq <= 3'(PM_LP4)) begin
               mode_nxt = ssv_pmode_e'(sleepModeReq);
               if (isDeep(ssv_pmode_e'(sleepModeReq))) begin
                  riskEntry_nxt = opt_r[OPT_DEFECT_BIT]
                     && (dirtyEntry || (fastWake && highDropsOff));
                  winCnt_nxt = WIN_LEN;
               end
               seq_nxt = SQ_SLEEP;
            end
         end
         SQ_SLEEP: begin
            // Window counts from entry; a later interrupt wakes normally
            if (winCnt_r != '0) begin
               winCnt_nxt = winCnt_r - CNT_W'(1);
            end
            if (irqSync_r) begin
               if (riskEntry_r && winCnt_r != '0) begin
                  seq_nxt = SQ_HUNG;
               end else begin
                  wakeCnt_nxt = (isDeep(mode_r) && !fastWake) ? SLOW_LEN : FAST_LEN;
                  seq_nxt = SQ_WAKE;
               end
            end
         end
         SQ_WAKE: begin
            if (wakeCnt_r <= CNT_W'(1)) begin
               mode_nxt = PM_ACTIVE;
               seq_nxt = SQ_RUN;
            end else begin
               wakeCnt_nxt = wakeCnt_r - CNT_W'(1);
            end
         end
         SQ_HUNG: begin
            // stays masked until power-up clear or reset
            mode_nxt = mode_r;
         end
      endcase
      if (pucSync_r) begin
         seq_nxt = SQ_RUN;
         mode_nxt = PM_ACTIVE;
         riskEntry_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lowCtl_r <= ssv_ctl_s'(LOW_CTL_RST);
         highCtl_r <= ssv_ctl_s'(HIGH_CTL_RST);
         opt_r <= OPT_RST;
         level_r <= 2'h0;
         coreRst_r <= 1'b0;
         ack_r <= 1'b0;
         rdata_r <= 32'h0;
         seq_r <= SQ_RUN;
         mode_r <= PM_ACTIVE;
         wakeCnt_r <= '0;
         winCnt_r <= '0;
         riskEntry_r <= 1'b0;
      end else if (clkEn) begin
         lowCtl_r <= lowCtl_nxt;
         highCtl_r <= highCtl_nxt;
         opt_r <= opt_nxt;
         level_r <= level_nxt;
         coreRst_r <= coreRst_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
         seq_r <= seq_nxt;
         mode_r <= mode_nxt;
         wakeCnt_r <= wakeCnt_nxt;
         winCnt_r <= winCnt_nxt;
         riskEntry_r <= riskEntry_nxt;
      end
   end

   // Mask CPU while asleep, while waking or while the hang holds it
   assign cpuMask = (seq_r != SQ_RUN);
   assign coreResetReq = coreRst_r;
   assign wakeHung = (seq_r == SQ_HUNG);
   // Core level moves only by register write; the request pin is not used yet
   assign coreLevel = level_r;
endmodule : ssv_supervisor_ctl

// [testbench/ssv_supervisor_ctl_asserts.sv]
// Port-level assertion checker for the supervisor control block
`timescale 1ns/10ps
module ssv_supervisor_ctl_asserts
   import ssv_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Bus
   input wire logic [3:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [31:0] avsReadData,
   input wire logic avsWaitRequest,
   // Sleep control and status
   input wire logic [2:0] sleepModeReq,
   input wire logic sleepEnter,
   input wire logic powerUpClear,
   input wire logic cpuMask,
   input wire logic coreResetReq,
   input wire logic wakeHung
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   AST_BUS_ANSWER: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
      else $error("bus request not answered next cycle");
   AST_BUS_IDLE: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest)
      else $error("waitrequest high with no request");
   AST_UNMAPPED_ZERO: assert property (avsRead && !avsWaitRequest && avsAddress > 4'h5
      |-> avsReadData == 32'h0) else $error("unmapped read not zero");
   AST_SLEEP_MASK: assert property (sleepEnter && !cpuMask && sleepModeReq >= 3'h3
      && sleepModeReq <= 3'h5 |=> cpuMask [*3])
      else $error("deep sleep entry did not mask the core");
   AST_HUNG_MASK: assert property (wakeHung |-> cpuMask)
      else $error("hung state without core mask");
   AST_HUNG_HOLD: assert property (wakeHung && !powerUpClear && !$past(powerUpClear)
      |=> wakeHung)
      else $error("hung state left without clear");
   AST_HUNG_CLEAR: assert property ($rose(powerUpClear) && wakeHung |-> ##[1:4] !wakeHung)
      else $error("power-up clear did not end hung state");
   // Clear only through a one written to the core reset flag
   AST_CORE_STICKY: assert property (coreResetReq
      && !(avsWrite && avsAddress == ADDR_FLAGS && avsWriteData[FLG_CORE_RST_BIT])
      |=> coreResetReq) else $error("core reset flag dropped on its own");
endmodule : ssv_supervisor_ctl_asserts

// [testbench/supply_supervisor_lpm_control_tb_top.sv]
// Self-checking bench for the supervisor control block
`timescale 1ns/10ps
module supply_supervisor_lpm_control_tb_top;
   import ssv_pkg::*;
   // Short settle and slow wake counts keep the run brief
   localparam int NCYC = 20;
   localparam int SCYC = 120;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avsAddress = 4'h0;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWriteData = 32'h0;
   logic [31:0] avsReadData;
   logic avsWaitRequest, cpuMask, coreResetReq, wakeHung;
   logic [2:0] sleepModeReq = 3'h0;
   logic sleepEnter = 1'b0;
   logic wakeIrqPin = 1'b0;
   logic powerUpClear = 1'b0;
   logic [1:0] coreLevel;
   ssv_pair_s lowState, highState;
   logic [31:0] rd;
   int failCount = 0;
   int nTests = 0;
   int cyc = 0;

   ssv_supervisor_ctl #(.NORM_CYC(NCYC), .SLOW_CYC(SCYC)) u_dut (.clk_sys(clk_sys),
      .reset(reset), .clkEn(1'b1), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hf),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .sleepModeReq(sleepModeReq), .sleepEnter(sleepEnter), .wakeIrqPin(wakeIrqPin),
      .powerUpClear(powerUpClear), .coreLevelReq(2'h0), .cpuMask(cpuMask),
      .coreResetReq(coreResetReq), .wakeHung(wakeHung), .coreLevel(coreLevel),
      .lowState(lowState), .highState(highState));

   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
   end

   task closeOut;
      if (failCount == 0 && nTests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : closeOut

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         failCount++;
      end
   endtask : chk

   // Holds the request until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWriteData <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (avsWaitRequest === 1'b0) break;
      end
      if (i == 20) chk("waitrequest", 0, 1);
      if (i == 20) closeOut();
      rd = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
   endtask : bus

   task waitSettle;
      int i;
      for (i = 0; i < 400; i++) begin
         bus(1'b0, ADDR_FLAGS, 32'h0);
         if (rd[1:0] === 2'h0) break;
      end
      if (i == 400) chk("settleTimeout", 0, 1);
      if (i == 400) closeOut();
   endtask : waitSettle

   task sleep(input logic [2:0] m);
      @(posedge clk_sys);
      sleepModeReq <= m;
      sleepEnter <= 1'b1;
      @(posedge clk_sys);
      sleepEnter <= 1'b0;
   endtask : sleep

   // Cycles from interrupt until the core mask drops
   task wake(output int n);
      @(posedge clk_sys);
      wakeIrqPin <= 1'b1;
      for (n = 0; n < 600 && cpuMask !== 1'b0; n++) @(posedge clk_sys);
      wakeIrqPin <= 1'b0;
      if (n == 600) chk("wakeTimeout", 0, 1);
      if (n == 600) closeOut();
   endtask : wake

   function automatic logic [3:0] expPair(input logic [5:0] c, input logic d);
      logic [1:0] s, m;
      s = 2'h0;
      m = 2'h0;
      if (c[0] && (!d || (c[1] && !c[5]))) s = c[2] ? 2'h2 : 2'h1;
      else if (c[0] && c[1]) s = {1'b0, c[2]};
      if (c[3]) m = (!d || !c[5]) ? (c[4] ? 2'h2 : 2'h1) : {1'b0, c[4]};
      return {s, m};
   endfunction : expPair

   task tReset;
      bus(1'b0, ADDR_LOW_CTL, 0);
      chk("lowCtl", 32'h05, rd);
      bus(1'b0, ADDR_HIGH_CTL, 0);
      chk("highCtl", 32'h05, rd);
      bus(1'b0, ADDR_OPT, 0);
      chk("opt", 32'h3, rd);
      bus(1'b1, 4'hf, 32'h3f);
      bus(1'b0, 4'hf, 0);
      chk("unmapped", 0, rd);
   endtask : tReset

   task tSettle;
      int c0;
      int len;
      for (int k = 0; k < 2; k++) begin
         len = k ? NCYC : FP_SETTLE_CYC;
         c0 = cyc;
         bus(1'b1, ADDR_LOW_CTL, k ? 32'h01 : 32'h05);
         bus(1'b0, ADDR_FLAGS, 0);
         chk("lowDelayFlag", 1, rd[0]);
         waitSettle();
         chk("settleLen", 1, (cyc - c0 >= len) && (cyc - c0 <= len + 9));
      end
      bus(1'b1, ADDR_MODE, 32'h1);
      waitSettle();
      chk("noCoreReset", 0, coreResetReq);
      chk("coreLevel", 1, coreLevel);
      bus(1'b1, ADDR_LOW_CTL, 32'h05);
      waitSettle();
      bus(1'b1, ADDR_MODE, 32'h2);
      bus(1'b0, ADDR_FLAGS, 0);
      chk("coreResetFlag", 1, rd[2]);
      chk("coreResetReq", 1, coreResetReq);
      bus(1'b1, ADDR_FLAGS, 32'h4);
      bus(1'b0, ADDR_FLAGS, 0);
      chk("coreResetClr", 0, rd[2]);
      waitSettle();
   endtask : tSettle

   task tTable;
      int n;
      logic [5:0] c;
      logic slow;
      for (int k = 0; k < 64; k++) begin
         c = 6'(k);
         slow = c[0] && !c[2] && c[3] && !c[4];
         bus(1'b1, ADDR_LOW_CTL, 32'(c));
         waitSettle();
         chk("activeState", expPair(c, 1'b0), lowState);
         bus(1'b0, ADDR_STATE, 0);
         chk("fastWake", !slow, rd[8]);
         sleep(3'(3 + k % 3));
         repeat (30) @(posedge clk_sys);
         chk("deepState", expPair(c, 1'b1), lowState);
         wake(n);
         n = n - (slow ? SCYC : WAKE_FAST_CYC);
         chk("wakeTime", 1, n >= 0 && n <= 5);
      end
   endtask : tTable

   task tHang(input logic [1:0] opt, input logic [5:0] hi, input logic settle, input logic h,
         input logic viaRst);
      bus(1'b1, ADDR_OPT, 32'(opt));
      bus(1'b1, ADDR_LOW_CTL, 32'h05);
      if (settle) waitSettle();
      bus(1'b1, ADDR_HIGH_CTL, 32'(hi));
      if (settle) waitSettle();
      bus(1'b0, ADDR_STATE, 0);
      chk("highState", expPair(hi, 1'b0), rd[7:4]);
      sleep(3'h4);
      @(posedge clk_sys);
      wakeIrqPin <= 1'b1;
      repeat (12) @(posedge clk_sys);
      chk("wakeHung", h, wakeHung);
      chk("highDeep", expPair(hi, 1'b1), highState);
      if (h) begin
         repeat (60) @(posedge clk_sys);
         chk("stillHung", 1, wakeHung & cpuMask);
         if (viaRst) begin
            reset <= 1'b1;
            repeat (5) @(posedge clk_sys);
            reset <= 1'b0;
         end else begin
            powerUpClear <= 1'b1;
            repeat (8) @(posedge clk_sys);
         end
         chk("hungCleared", 0, wakeHung);
         powerUpClear <= 1'b0;
      end
      wakeIrqPin <= 1'b0;
      repeat (80) @(posedge clk_sys);
      chk("running", 0, cpuMask);
   endtask : tHang

   initial begin
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      tReset();
      tSettle();
      tTable();
      tHang(2'h3, 6'h05, 1'b0, 1'b1, 1'b0);
      tHang(2'h3, 6'h01, 1'b1, 1'b1, 1'b1);
      tHang(2'h2, 6'h01, 1'b1, 1'b0, 1'b0);
      closeOut();
   end
endmodule : supply_supervisor_lpm_control_tb_top

bind ssv_supervisor_ctl ssv_supervisor_ctl_asserts u_chk (.clk_sys(clk_sys), .reset(reset),
   .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
   .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
   .sleepModeReq(sleepModeReq), .sleepEnter(sleepEnter), .powerUpClear(powerUpClear),
   .cpuMask(cpuMask), .coreResetReq(coreResetReq), .wakeHung(wakeHung));
